// ==== dual_mac_consts.vh ====
// Purpose: Shared constants for the dual multiply-accumulate operand datapath.
// Assumes: Word addressing on all three read buses.
// Notes:   Block size and internal memory limit are build-time choices.
`ifndef DUAL_MAC_CONSTS_VH
`define DUAL_MAC_CONSTS_VH

`define DM_ADDR_W        24
`define DM_DATA_W        16
`define DM_ACC_W         40
`define DM_PROD_W        32
`define DM_PTR_N         8
`define DM_SEL_W         3
`define DM_WSEL_W        4
`define DM_WSEL_COEF     4'h8
`define DM_BLK_LSB       13
`define DM_BLK_W         11
`define DM_INT_MEM_LIMIT 24'h020000
`define DM_ACC_RESET     40'h0000000000
`define DM_PTR_RESET     24'h000000
`define DM_PTR_STEP      24'h000001
`define DM_BLOCK_ACCESS_LIMIT 2'h2

`endif

// ==== mac_unit.v ====
// Purpose: One multiply-accumulate unit with an add or subtract update.
// Assumes: Signed operands; the product is sign-extended into the accumulator.
// Notes:   Clear has priority over an update in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "dual_mac_consts.vh"

module mac_unit (
  input  wire                     clk_i,
  input  wire                     rstn_i,
  input  wire                     ce_i,
  input  wire                     clr_i,
  input  wire                     en_i,
  input  wire                     sub_i,
  input  wire [`DM_DATA_W-1:0]    a_i,
  input  wire [`DM_DATA_W-1:0]    b_i,
  output reg  [`DM_ACC_W-1:0]     acc_o
);

  wire signed [`DM_PROD_W-1:0] prod;
  wire        [`DM_ACC_W-1:0]  prod_ext;

  assign prod     = $signed(a_i) * $signed(b_i);
  assign prod_ext = {{(`DM_ACC_W-`DM_PROD_W){prod[`DM_PROD_W-1]}}, prod};

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_o <= `DM_ACC_RESET;
    end else if (ce_i) begin
      if (clr_i) begin
        acc_o <= `DM_ACC_RESET;
      end else if (en_i) begin
        if (sub_i) begin
          acc_o <= acc_o - prod_ext;
        end else begin
          acc_o <= acc_o + prod_ext;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== dual_mac_operand_datapath.v ====
// Purpose: Dual multiply-accumulate datapath fed by three operand read buses.
// Assumes: Memory answers each read request with data one cycle later.
// Notes:   A block conflict splits the fetch over two cycles.
`timescale 1ns/1ps
`default_nettype none
`include "dual_mac_consts.vh"

module dual_mac_operand_datapath (
  input  wire                    clk_i,
  input  wire                    rstn_i,
  input  wire                    ce_i,
  input  wire                    ptr_wr_i,
  input  wire [`DM_WSEL_W-1:0]   ptr_wsel_i,
  input  wire [`DM_ADDR_W-1:0]   ptr_wdata_i,
  input  wire                    issue_i,
  input  wire                    sub_first_i,
  input  wire                    sub_second_i,
  input  wire [`DM_SEL_W-1:0]    first_sel_i,
  input  wire [`DM_SEL_W-1:0]    second_sel_i,
  input  wire                    first_inc_i,
  input  wire                    second_inc_i,
  input  wire                    coef_inc_i,
  input  wire                    acc_clr_i,
  output wire                    ready_o,
  output wire                    coefficient_bus_req_o,
  output wire [`DM_ADDR_W-1:0]   coefficient_bus_addr_o,
  input  wire [`DM_DATA_W-1:0]   coefficient_bus_data_i,
  output wire                    first_read_bus_req_o,
  output wire [`DM_ADDR_W-1:0]   first_read_bus_addr_o,
  input  wire [`DM_DATA_W-1:0]   first_read_bus_data_i,
  output wire                    second_read_bus_req_o,
  output wire [`DM_ADDR_W-1:0]   second_read_bus_addr_o,
  input  wire [`DM_DATA_W-1:0]   second_read_bus_data_i,
  output wire [`DM_ACC_W-1:0]    first_accumulator_o,
  output wire [`DM_ACC_W-1:0]    second_accumulator_o,
  output reg                     done_o,
  output reg                     coef_ext_err_o
);

  localparam S_RUN   = 1'b0;
  localparam S_SPLIT = 1'b1;

  reg  [`DM_ADDR_W-1:0] extended_auxiliary_pointers_q [0:`DM_PTR_N-1];
  reg  [`DM_ADDR_W-1:0] extended_coefficient_pointer_q;
  reg                   state_q;
  reg                   state_d;
  reg                   p1_valid_q;
  reg                   p1_split_q;
  reg                   p1_sub0_q;
  reg                   p1_sub1_q;
  reg                   p2_valid_q;
  reg                   p2_sub0_q;
  reg                   p2_sub1_q;
  reg  [`DM_ADDR_W-1:0] y_addr_q;
  reg  [`DM_DATA_W-1:0] hold_coef_q;
  reg  [`DM_DATA_W-1:0] hold_first_q;

  wire [`DM_ADDR_W-1:0] x_addr;
  wire [`DM_ADDR_W-1:0] y_addr;
  wire [`DM_ADDR_W-1:0] c_addr;
  wire [`DM_BLK_W-1:0]  c_blk;
  wire [`DM_BLK_W-1:0]  x_blk;
  wire [`DM_BLK_W-1:0]  y_blk;
  wire [1:0]            c_blk_uses;
  wire                  overload;
  wire                  coef_external;
  wire                  accept;
  wire                  exec;
  wire                  exec_sub0;
  wire                  exec_sub1;
  wire [`DM_DATA_W-1:0] op_coef;
  wire [`DM_DATA_W-1:0] op_first;

  // Both operand addresses may come from any auxiliary pointer.
  assign x_addr = extended_auxiliary_pointers_q[first_sel_i];
  assign y_addr = extended_auxiliary_pointers_q[second_sel_i];
  // No other pointer can steer the coefficient fetch.
  assign c_addr = extended_coefficient_pointer_q;

  assign c_blk = c_addr[`DM_BLK_LSB +: `DM_BLK_W];
  assign x_blk = x_addr[`DM_BLK_LSB +: `DM_BLK_W];
  assign y_blk = y_addr[`DM_BLK_LSB +: `DM_BLK_W];

  // Accesses landing in the coefficient's block, counting the coefficient itself.
  assign c_blk_uses = {1'b0, (c_blk == x_blk)} + {1'b0, (c_blk == y_blk)}
                    + 2'h1;
  assign overload = (c_blk_uses > `DM_BLOCK_ACCESS_LIMIT);

  // The coefficient bus cannot reach external memory, so such a fetch is refused.
  assign coef_external = (c_addr >= `DM_INT_MEM_LIMIT);

  assign ready_o = (state_q == S_RUN);
  assign accept  = ready_o && issue_i && !coef_external;

  // Exactly three fetches per dual operation, one per bus.
  assign coefficient_bus_req_o  = accept;
  assign coefficient_bus_addr_o = c_addr;
  assign first_read_bus_req_o   = accept;
  assign first_read_bus_addr_o  = x_addr;
  // An overloaded block defers the second operand one cycle.
  assign second_read_bus_req_o  = (accept && !overload) || (state_q == S_SPLIT);
  assign second_read_bus_addr_o = (state_q == S_SPLIT) ? y_addr_q : y_addr;

  // Execution waits until the last operand has really arrived.
  assign exec      = (p1_valid_q && !p1_split_q) || p2_valid_q;
  assign exec_sub0 = p2_valid_q ? p2_sub0_q : p1_sub0_q;
  assign exec_sub1 = p2_valid_q ? p2_sub1_q : p1_sub1_q;
  assign op_coef   = p2_valid_q ? hold_coef_q : coefficient_bus_data_i;
  assign op_first  = p2_valid_q ? hold_first_q : first_read_bus_data_i;

  always @* begin
    state_d = state_q;
    case (state_q)
      S_RUN: begin
        if (accept && overload) begin
          state_d = S_SPLIT;
        end
      end
      S_SPLIT: begin
        state_d = S_RUN;
      end
      default: begin
        state_d = S_RUN;
      end
    endcase
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q        <= S_RUN;
      p1_valid_q     <= 1'b0;
      p1_split_q     <= 1'b0;
      p1_sub0_q      <= 1'b0;
      p1_sub1_q      <= 1'b0;
      p2_valid_q     <= 1'b0;
      p2_sub0_q      <= 1'b0;
      p2_sub1_q      <= 1'b0;
      y_addr_q       <= `DM_PTR_RESET;
      hold_coef_q    <= {`DM_DATA_W{1'b0}};
      hold_first_q   <= {`DM_DATA_W{1'b0}};
      done_o         <= 1'b0;
      coef_ext_err_o <= 1'b0;
    end else if (ce_i) begin
      state_q        <= state_d;
      p1_valid_q     <= accept;
      p1_split_q     <= accept && overload;
      p1_sub0_q      <= sub_first_i;
      p1_sub1_q      <= sub_second_i;
      p2_valid_q     <= p1_valid_q && p1_split_q;
      p2_sub0_q      <= p1_sub0_q;
      p2_sub1_q      <= p1_sub1_q;
      done_o         <= exec;
      coef_ext_err_o <= ready_o && issue_i && coef_external;
      if (accept) begin
        y_addr_q <= y_addr;
      end
      // Early operands are parked so the deferred cycle does not reuse stale bus data.
      if (p1_valid_q && p1_split_q) begin
        hold_coef_q  <= coefficient_bus_data_i;
        hold_first_q <= first_read_bus_data_i;
      end
    end
  end

  // Pointer loads win over post-increment of the same pointer.
  genvar g;
  generate
    for (g = 0; g < `DM_PTR_N; g = g + 1) begin : g_aux
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          extended_auxiliary_pointers_q[g] <= `DM_PTR_RESET;
        end else if (ce_i) begin
          if (ptr_wr_i && (ptr_wsel_i == g[`DM_WSEL_W-1:0])) begin
            extended_auxiliary_pointers_q[g] <= ptr_wdata_i;
          end else if (accept && ((first_inc_i && (first_sel_i == g[`DM_SEL_W-1:0])) ||
                                  (second_inc_i && (second_sel_i == g[`DM_SEL_W-1:0])))) begin
            extended_auxiliary_pointers_q[g] <= extended_auxiliary_pointers_q[g] +
                                                `DM_PTR_STEP;
          end
        end
      end
    end
  endgenerate

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      extended_coefficient_pointer_q <= `DM_PTR_RESET;
    end else if (ce_i) begin
      if (ptr_wr_i && (ptr_wsel_i == `DM_WSEL_COEF)) begin
        extended_coefficient_pointer_q <= ptr_wdata_i;
      end else if (accept && coef_inc_i) begin
        extended_coefficient_pointer_q <= extended_coefficient_pointer_q + `DM_PTR_STEP;
      end
    end
  end

  // Both units share one enable, so their updates land on the same edge.
  mac_unit u_mac_first (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .ce_i   (ce_i),
    .clr_i  (acc_clr_i),
    .en_i   (exec),
    .sub_i  (exec_sub0),
    .a_i    (op_first),
    .b_i    (op_coef),
    .acc_o  (first_accumulator_o)
  );

  mac_unit u_mac_second (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .ce_i   (ce_i),
    .clr_i  (acc_clr_i),
    .en_i   (exec),
    .sub_i  (exec_sub1),
    .a_i    (second_read_bus_data_i),
    .b_i    (op_coef),
    .acc_o  (second_accumulator_o)
  );

endmodule
`default_nettype wire

// ==== operand_mem.sv ====
// Purpose: Operand memory port that answers a read one cycle after its request.
// Assumes: Each stored word is the low 16 address bits scrambled by a fixed mask.
// Notes:   Idle cycles show the inverted last word, so a stale sample cannot match.
`timescale 1ns/1ps
`default_nettype none
module operand_mem (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic [23:0] addr_i,
  output var  logic [15:0] data_o
);
  initial data_o = 16'h0000;
  // One port serves one access per cycle; the datapath must split any overload.
  always @(posedge clk_i) begin
    data_o <= req_i ? (addr_i[15:0] ^ 16'hA5C3) : ~data_o;
  end
endmodule
`default_nettype wire

// ==== dual_mac_operand_datapath_checker.sv ====
// Purpose: Port-level timing checks for the dual multiply-accumulate datapath.
// Assumes: Clock enable stays high whenever an operation is in flight.
// Notes:   Latencies are the fixed two and three cycles of the normal and split walks.
`timescale 1ns/1ps
`default_nettype none
`include "dual_mac_consts.vh"
module dual_mac_checker (
  input wire logic                  clk_i,
  input wire logic                  rstn_i,
  input wire logic                  ce_i,
  input wire logic                  issue_i,
  input wire logic                  ready_o,
  input wire logic                  coefficient_bus_req_o,
  input wire logic [`DM_ADDR_W-1:0] coefficient_bus_addr_o,
  input wire logic                  first_read_bus_req_o,
  input wire logic                  second_read_bus_req_o,
  input wire logic                  done_o,
  input wire logic                  coef_ext_err_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  pair_req_a: assert property (coefficient_bus_req_o |-> first_read_bus_req_o)
    else $error("coefficient fetch without first operand");
  normal_lat_a: assert property (ce_i && coefficient_bus_req_o && second_read_bus_req_o
    |-> ##2 done_o) else $error("dual operation not done in two cycles");
  split_seq_a: assert property (ce_i && coefficient_bus_req_o && !second_read_bus_req_o
    |=> !ready_o && second_read_bus_req_o) else $error("split cycle missing");
  split_lat_a: assert property (ce_i && coefficient_bus_req_o && !second_read_bus_req_o
    |-> ##3 done_o) else $error("split operation not done in three cycles");
  ext_refuse_a: assert property (ce_i && issue_i && ready_o
    && coefficient_bus_addr_o >= `DM_INT_MEM_LIMIT |-> !coefficient_bus_req_o ##1 coef_ext_err_o)
    else $error("external coefficient not refused");
  coef_int_a: assert property (coefficient_bus_req_o
    |-> coefficient_bus_addr_o < `DM_INT_MEM_LIMIT) else $error("coefficient fetch outside");
  done_src_a: assert property (done_o |-> $past(second_read_bus_req_o, 2))
    else $error("done without second operand fetch");
  ready_back_a: assert property (ce_i && !ready_o |=> ready_o)
    else $error("stall longer than one cycle");
  stall_cause_a: assert property (!ready_o |-> $past(coefficient_bus_req_o))
    else $error("stall without preceding accept");
  cover property (done_o);
  cover property (!ready_o);
  cover property (coef_ext_err_o);
endmodule
bind dual_mac_operand_datapath dual_mac_checker u_chk (.clk_i, .rstn_i, .ce_i, .issue_i,
  .ready_o, .coefficient_bus_req_o, .coefficient_bus_addr_o, .first_read_bus_req_o,
  .second_read_bus_req_o, .done_o, .coef_ext_err_o);
`default_nettype wire

// ==== dual_mac_operand_datapath_tb.sv ====
// Purpose: Self-checking bench for the dual multiply-accumulate datapath.
// Assumes: Operand words are the scrambled addresses served by the memory model.
// Notes:   Clock enable is dropped only while no operation is in flight.
`timescale 1ns/1ps
`default_nettype none
`include "dual_mac_consts.vh"
module dual_mac_operand_datapath_tb;
  logic clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, ptr_wr_i = 1'b0, issue_i = 1'b0;
  logic sub_first_i = 1'b0, sub_second_i = 1'b0, acc_clr_i = 1'b0;
  logic first_inc_i = 1'b0, second_inc_i = 1'b0, coef_inc_i = 1'b0;
  logic [3:0]  ptr_wsel_i = 4'h0;
  logic [23:0] ptr_wdata_i = 24'h000000;
  logic [2:0]  first_sel_i = 3'h0, second_sel_i = 3'h0;
  wire         ready_o, done_o, err, c_req, f_req, s_req;
  wire  [23:0] c_addr, f_addr, s_addr;
  wire  [15:0] c_dat, f_dat, s_dat;
  wire  [39:0] a1, a2;
  logic [23:0] p [0:8];
  logic signed [39:0] e1 = 40'sh0, e2 = 40'sh0;
  int n_errors = 0, n_compared = 0;
  always #20 clk_i = ~clk_i;
  dual_mac_operand_datapath DUT (.clk_i, .rstn_i, .ce_i, .ptr_wr_i, .ptr_wsel_i, .ptr_wdata_i,
    .issue_i, .sub_first_i, .sub_second_i, .first_sel_i, .second_sel_i, .first_inc_i,
    .second_inc_i, .coef_inc_i, .acc_clr_i, .ready_o, .coefficient_bus_req_o(c_req),
    .coefficient_bus_addr_o(c_addr), .coefficient_bus_data_i(c_dat),
    .first_read_bus_req_o(f_req), .first_read_bus_addr_o(f_addr),
    .first_read_bus_data_i(f_dat), .second_read_bus_req_o(s_req),
    .second_read_bus_addr_o(s_addr), .second_read_bus_data_i(s_dat),
    .first_accumulator_o(a1), .second_accumulator_o(a2), .done_o, .coef_ext_err_o(err));
  operand_mem u_cm (.clk_i, .req_i(c_req), .addr_i(c_addr), .data_o(c_dat));
  operand_mem u_fm (.clk_i, .req_i(f_req), .addr_i(f_addr), .data_o(f_dat));
  operand_mem u_sm (.clk_i, .req_i(s_req), .addr_i(s_addr), .data_o(s_dat));
  function automatic logic signed [31:0] prod(input logic [23:0] a, input logic [23:0] b);
    prod = $signed(a[15:0] ^ 16'hA5C3) * $signed(b[15:0] ^ 16'hA5C3);
  endfunction
  task chk(input string n, input logic [39:0] s, input logic [39:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task ld(input logic [3:0] w, input logic [23:0] v);
    ptr_wr_i = 1'b1;
    ptr_wsel_i = w;
    ptr_wdata_i = v;
    p[w] = v;
    @(posedge clk_i);
    #1;
  endtask
  task clr;
    acc_clr_i = 1'b1;
    @(posedge clk_i);
    #1 acc_clr_i = 1'b0;
    e1 = 40'sh0;
    e2 = 40'sh0;
  endtask
  task accs;
    chk("first accumulator", a1, e1);
    chk("second accumulator", a2, e2);
  endtask
  // The mode word packs coefficient, second and first increments, then both subtract flags.
  task op(input logic [2:0] fs, input logic [2:0] ss, input logic [4:0] m);
    logic ovl;
    // Three fetches into one block exceed its two accesses, so the second fetch waits.
    ovl = (p[8][`DM_BLK_LSB +: `DM_BLK_W] == p[fs][`DM_BLK_LSB +: `DM_BLK_W]) &&
          (p[8][`DM_BLK_LSB +: `DM_BLK_W] == p[ss][`DM_BLK_LSB +: `DM_BLK_W]);
    issue_i = 1'b1;
    first_sel_i = fs;
    second_sel_i = ss;
    {coef_inc_i, second_inc_i, first_inc_i, sub_second_i, sub_first_i} = m;
    #5 chk("coefficient address", c_addr, p[8]);
    chk("first address", f_addr, p[fs]);
    chk("second address", s_addr, p[ss]);
    chk("coefficient and first fetch", {c_req, f_req}, 2'b11);
    chk("second fetch", s_req, !ovl);
    e1 = m[0] ? e1 - prod(p[fs], p[8]) : e1 + prod(p[fs], p[8]);
    e2 = m[1] ? e2 - prod(p[ss], p[8]) : e2 + prod(p[ss], p[8]);
    p[fs] = p[fs] + m[2];
    p[ss] = p[ss] + m[3];
    p[8] = p[8] + m[4];
    @(posedge clk_i);
    #1;
  endtask
  // Eight back-to-back operations walk every pointer and every add or subtract pairing.
  task s_burst;
    clr;
    for (int i = 0; i < 8; i++) ld(i[3:0], 24'h002000 * (i + 1) + 24'h000135 * i);
    ld(4'h8, 24'h000021);
    ptr_wr_i = 1'b0;
    for (int i = 0; i < 8; i++) op(i[2:0], i[2:0] + 3'h1, {3'b111, i[1:0]});
    issue_i = 1'b0;
    @(posedge clk_i);
    #1 chk("burst done", done_o, 1'b1);
    accs;
  endtask
  task s_split;
    clr;
    ld(4'h0, 24'h000300);
    ld(4'h1, 24'h000500);
    ld(4'h8, 24'h000700);
    ptr_wr_i = 1'b0;
    op(3'h0, 3'h1, 5'h03);
    issue_i = 1'b0;
    chk("stall ready", ready_o, 1'b0);
    chk("second fetch deferred", s_req, 1'b1);
    chk("held second address", s_addr, 24'h000500);
    repeat (2) @(posedge clk_i);
    #1 chk("split done", done_o, 1'b1);
    accs;
  endtask
  // One idle cycle first lets the last done pulse drop before the freeze holds it.
  task s_freeze;
    @(posedge clk_i);
    #1 ce_i = 1'b0;
    acc_clr_i = 1'b1;
    ptr_wr_i = 1'b1;
    ptr_wsel_i = 4'h8;
    ptr_wdata_i = 24'h000123;
    repeat (2) @(posedge clk_i);
    #1 ce_i = 1'b1;
    acc_clr_i = 1'b0;
    ptr_wr_i = 1'b0;
    chk("frozen pointer", c_addr, p[8]);
    chk("frozen done", done_o, 1'b0);
    accs;
  endtask
  task s_ext;
    clr;
    ld(4'h8, `DM_INT_MEM_LIMIT);
    ptr_wr_i = 1'b0;
    coef_inc_i = 1'b1;
    issue_i = 1'b1;
    #5 chk("no coefficient fetch", c_req, 1'b0);
    @(posedge clk_i);
    #1 issue_i = 1'b0;
    chk("refusal flag", err, 1'b1);
    @(posedge clk_i);
    #1 chk("pointer kept", c_addr, `DM_INT_MEM_LIMIT);
    accs;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    accs;
    s_burst;
    s_split;
    s_freeze;
    s_ext;
    end_sim;
  end
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
